// >>> logic/gpio_pin_cell.sv
`timescale 1ns/10ps
module gpio_pin_cell import gpio_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic data_bit_in,
   input pin_mode_t mode_in,
   input wire logic clear_in,
   output logic sampled_out,
   output logic req_out
);
   // ****************************************
   // sampling
   // ****************************************
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic req_r;
   logic rise;
   logic fall;
   logic lvl_match;
   logic edge_mode;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   assign sampled_out = sync2_r;
   assign rise = sync2_r & ~prev_r;
   assign fall = ~sync2_r & prev_r;
   assign lvl_match = (sync2_r == data_bit_in) && (prev_r == data_bit_in);
   assign edge_mode = (mode_in == MODE_DUAL_EDGE) || (mode_in == MODE_SINGLE_EDGE);

   // ****************************************
   // request latch
   // ****************************************
   // a new edge beats a clear in the same cycle so no event is lost
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_r <= 1'b0;
      end else begin
         case (mode_in)
            MODE_DUAL_EDGE: begin
               if (rise || fall) begin
                  req_r <= 1'b1;
               end else if (clear_in) begin
                  req_r <= 1'b0;
               end
            end
            MODE_SINGLE_EDGE: begin
               if (data_bit_in ? rise : fall) begin
                  req_r <= 1'b1;
               end else if (clear_in) begin
                  req_r <= 1'b0;
               end
            end
            MODE_LEVEL: begin
               req_r <= lvl_match;
            end
            default: begin
               req_r <= 1'b0;
            end
         endcase
      end
   end

   assign req_out = req_r;

   // ****************************************
   // checks
   // ****************************************
   dual_edge_req_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_in == MODE_DUAL_EDGE && (rise || fall) && $stable(mode_in)) |=> req_r)
      else $error("dual edge did not raise request");
   single_edge_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_in == MODE_SINGLE_EDGE && req_r && !clear_in) ##1 (mode_in == MODE_SINGLE_EDGE) |-> req_r)
      else $error("single edge request dropped without clear");
   edge_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (edge_mode && clear_in && !rise && !fall) ##1 edge_mode |-> !req_r)
      else $error("edge request not cleared by write of one");
   wrong_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_in == MODE_SINGLE_EDGE && !req_r && !(data_bit_in ? rise : fall)) ##1
      (mode_in == MODE_SINGLE_EDGE) |-> !req_r)
      else $error("single edge request from wrong edge");
   level_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_in == MODE_LEVEL && $rose(req_r)) |-> ($past(sync2_r, 1) == $past(data_bit_in, 1)) &&
      ($past(prev_r, 1) == $past(data_bit_in, 1)))
      else $error("level request without two matching samples");
   level_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_in == MODE_LEVEL && sync2_r != data_bit_in) |=> !req_r)
      else $error("level request held after mismatch");
endmodule : gpio_pin_cell

// >>> logic/gpio_pkg.sv
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
package gpio_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int NUM_PORTS = 3;
   localparam int PORT_W = 8;
   localparam int NUM_PINS = 24;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************
   // register indices, byte address is index times four
   // ****************************************
   localparam logic [7:0] IDX_PB_DATA = 8'h9A;
   localparam logic [7:0] IDX_PC_DATA = 8'h9E;
   localparam logic [7:0] IDX_PD_DATA = 8'hA2;
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_DDR = 8'h01;
   localparam logic [7:0] OFS_ALT1 = 8'h02;
   localparam logic [7:0] OFS_ALT2 = 8'h03;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hB0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;

   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] DDR_RST = 8'hFF;
   localparam logic [7:0] ALT_RST = 8'h00;
   localparam logic [23:0] MASK_RST = 24'h000000;
   localparam int LEVEL_HOLD_CYCLES = 2;

   // ****************************************
   // pin modes
   // ****************************************
   typedef enum logic [2:0] {
      MODE_OUTPUT,
      MODE_INPUT,
      MODE_HIZ,
      MODE_DUAL_EDGE,
      MODE_ALT,
      MODE_LEVEL,
      MODE_SINGLE_EDGE
   } pin_mode_t;

   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } apb_req_t;

   // mode code is {alt2, alt1, ddr}
   function automatic pin_mode_t decode_mode(input logic ddr, input logic alt1, input logic alt2);
      case ({alt2, alt1, ddr})
         3'h0: decode_mode = MODE_OUTPUT;
         3'h1: decode_mode = MODE_INPUT;
         3'h2: decode_mode = MODE_HIZ;
         3'h3: decode_mode = MODE_DUAL_EDGE;
         3'h4: decode_mode = MODE_ALT;
         3'h5: decode_mode = MODE_LEVEL;
         3'h6: decode_mode = MODE_SINGLE_EDGE;
         default: decode_mode = MODE_INPUT;
      endcase
   endfunction : decode_mode
endpackage : gpio_pkg

// >>> logic/gpio_port.sv
`timescale 1ns/10ps
module gpio_port import gpio_pkg::*; (
   input wire logic SYS_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [ADDR_W-1:0] PADDR_IN,
   input wire logic [DATA_W-1:0] PWDATA_IN,
   output logic [DATA_W-1:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic [NUM_PINS-1:0] PIN_IN,
   output logic [NUM_PINS-1:0] PIN_OUT,
   output logic [NUM_PINS-1:0] PIN_OE_OUT,
   input wire logic [NUM_PINS-1:0] ALT_DATA_IN,
   input wire logic [NUM_PINS-1:0] ALT_OE_IN,
   output logic [NUM_PINS-1:0] ALT_SAMPLED_OUT,
   output logic IRQ_OUT
);
   // ****************************************
   // register storage
   // ****************************************
   logic [PORT_W-1:0] data_r [NUM_PORTS];
   logic [PORT_W-1:0] ddr_r [NUM_PORTS];
   logic [PORT_W-1:0] alt1_r [NUM_PORTS];
   logic [PORT_W-1:0] alt2_r [NUM_PORTS];
   logic [NUM_PINS-1:0] status_r;
   logic [NUM_PINS-1:0] mask_r;
   logic [DATA_W-1:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [NUM_PINS-1:0] pin_out_r;
   logic [NUM_PINS-1:0] pin_oe_r;
   logic [NUM_PINS-1:0] alt_sampled_r;
   logic irq_r;
   logic [NUM_PINS-1:0] sampled;
   logic [NUM_PINS-1:0] req;
   logic [NUM_PINS-1:0] clear;
   pin_mode_t mode [NUM_PINS];
   apb_req_t bus;
   logic [7:0] idx;
   logic hit_any;
   logic wr_take;

   // ****************************************
   // apb decode
   // ****************************************
   function automatic logic [7:0] port_base(input int p);
      case (p)
         0: port_base = IDX_PB_DATA;
         1: port_base = IDX_PC_DATA;
         default: port_base = IDX_PD_DATA;
      endcase
   endfunction : port_base

   function automatic logic port_hit(input logic [7:0] i);
      port_hit = 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (i >= port_base(p) && i <= port_base(p) + OFS_ALT2) begin
            port_hit = 1'b1;
         end
      end
   endfunction : port_hit

   assign bus = '{wr: PWRITE_IN, addr: PADDR_IN, wdata: PWDATA_IN};
   // upper address bits must be zero so aliases are refused
   assign idx = (bus.addr[ADDR_W-1:10] == 2'b00) ? bus.addr[9:2] : 8'hFF;
   assign hit_any = port_hit(idx) || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
   // a write lands only at the edge where pready is seen high
   assign wr_take = PSEL_IN && PENABLE_IN && pready_r && bus.wr && hit_any;

   // one wait state: pready comes one cycle into the access phase
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= PSEL_IN && PENABLE_IN && !pready_r;
         pslverr_r <= PSEL_IN && PENABLE_IN && !pready_r && !hit_any;
      end
   end

   // read mux, captured together with pready
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         prdata_r <= '0;
      end else if (PSEL_IN && PENABLE_IN && !pready_r) begin
         prdata_r <= '0;
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (idx == port_base(p) + OFS_DATA) begin
               prdata_r[PORT_W-1:0] <= sampled[p*PORT_W +: PORT_W];
            end
            if (idx == port_base(p) + OFS_DDR) begin
               prdata_r[PORT_W-1:0] <= ddr_r[p];
            end
            if (idx == port_base(p) + OFS_ALT1) begin
               prdata_r[PORT_W-1:0] <= alt1_r[p];
            end
            if (idx == port_base(p) + OFS_ALT2) begin
               prdata_r[PORT_W-1:0] <= alt2_r[p];
            end
         end
         if (idx == IDX_IRQ_STATUS) begin
            prdata_r[NUM_PINS-1:0] <= status_r;
         end
         if (idx == IDX_IRQ_MASK) begin
            prdata_r[NUM_PINS-1:0] <= mask_r;
         end
      end
   end

   // ****************************************
   // port control registers
   // ****************************************
   // four registers per port, three ports
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            data_r[p] <= DATA_RST;
            ddr_r[p] <= DDR_RST;
            alt1_r[p] <= ALT_RST;
            alt2_r[p] <= ALT_RST;
         end
      end else if (wr_take) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (idx == port_base(p) + OFS_DATA) begin
               data_r[p] <= bus.wdata[PORT_W-1:0];
            end
            if (idx == port_base(p) + OFS_DDR) begin
               ddr_r[p] <= bus.wdata[PORT_W-1:0];
            end
            if (idx == port_base(p) + OFS_ALT1) begin
               alt1_r[p] <= bus.wdata[PORT_W-1:0];
            end
            if (idx == port_base(p) + OFS_ALT2) begin
               alt2_r[p] <= bus.wdata[PORT_W-1:0];
            end
         end
      end
   end

   // ****************************************
   // per pin logic
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         localparam int P = g / PORT_W;
         localparam int B = g % PORT_W;
         assign mode[g] = decode_mode(ddr_r[P][B], alt1_r[P][B], alt2_r[P][B]);
         // a one in the data write clears an edge request
         assign clear[g] = wr_take && idx == port_base(P) + OFS_DATA && bus.wdata[B];
         gpio_pin_cell u_cell (
            .clk_in(SYS_CLK_IN),
            .rst_n_in(RESET_N_IN),
            .pin_in(PIN_IN[g]),
            .data_bit_in(data_r[P][B]),
            .mode_in(mode[g]),
            .clear_in(clear[g]),
            .sampled_out(sampled[g]),
            .req_out(req[g])
         );
      end
   endgenerate

   // pin drivers; only output and alternate modes ever enable the pad
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            case (mode[i])
               MODE_OUTPUT: begin
                  pin_out_r[i] <= data_r[i / PORT_W][i % PORT_W];
                  pin_oe_r[i] <= 1'b1;
               end
               MODE_ALT: begin
                  pin_out_r[i] <= ALT_DATA_IN[i];
                  pin_oe_r[i] <= ALT_OE_IN[i];
               end
               default: begin
                  pin_out_r[i] <= 1'b0;
                  pin_oe_r[i] <= 1'b0;
               end
            endcase
         end
      end
   end

   // alternate function sees the clock-sampled pin, never the raw pad
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         alt_sampled_r <= '0;
      end else begin
         alt_sampled_r <= sampled;
      end
   end

   // ****************************************
   // interrupt status and mask
   // ****************************************
   // sticky status; a pending request wins over a write-one clear
   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         status_r <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (req[i]) begin
               status_r[i] <= 1'b1;
            end else if (wr_take && idx == IDX_IRQ_STATUS && bus.wdata[i]) begin
               status_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         mask_r <= MASK_RST;
      end else if (wr_take && idx == IDX_IRQ_MASK) begin
         mask_r <= bus.wdata[NUM_PINS-1:0];
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   assign PRDATA_OUT = prdata_r;
   assign PREADY_OUT = pready_r;
   assign PSLVERR_OUT = pslverr_r;
   assign PIN_OUT = pin_out_r;
   assign PIN_OE_OUT = pin_oe_r;
   assign ALT_SAMPLED_OUT = alt_sampled_r;
   assign IRQ_OUT = irq_r;

   // ****************************************
   // checks
   // ****************************************
   ready_one_wait_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (PSEL_IN && PENABLE_IN && !pready_r) |=> pready_r ##1 !pready_r)
      else $error("pready not one cycle after access start");
   hiz_mode_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (mode[8] == MODE_HIZ) |=> !pin_oe_r[8])
      else $error("reserved mode drives pin");
   output_mode_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (mode[9] == MODE_OUTPUT) |=> pin_oe_r[9] && pin_out_r[9] == $past(data_r[1][1]))
      else $error("output mode not driving data bit");
   alt_mode_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (mode[17] == MODE_ALT) |=> pin_oe_r[17] == $past(ALT_OE_IN[17]) && pin_out_r[17] == $past(ALT_DATA_IN[17]))
      else $error("alternate mode not passed through");
   data_read_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      (PSEL_IN && PENABLE_IN && !pready_r && !bus.wr && idx == IDX_PC_DATA) |=>
      prdata_r[PORT_W-1:0] == $past(sampled[15:8]))
      else $error("data read not sampled pins");
   irq_level_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
      ##1 (irq_r == $past(|(status_r & mask_r))))
      else $error("interrupt output wrong");
endmodule : gpio_port

// >>> tb/pin_model.sv
`timescale 1ns/10ps
// ****************************************
// board side of the pads
// ****************************************
module pin_model import gpio_pkg::*; (
   input wire logic [NUM_PINS-1:0] pad_out_in,
   input wire logic [NUM_PINS-1:0] pad_oe_in,
   input wire logic [NUM_PINS-1:0] ext_in,
   output logic [NUM_PINS-1:0] pin_out
);
   // the device wins where it drives; elsewhere the board source holds the line,
   // so a released pad never keeps showing the last driven value
   assign pin_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_in);
endmodule : pin_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench import gpio_pkg::*; ;
   logic clk, rst_n, psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdata;
   logic pready, pslverr, irq, rerr;
   logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, alt_data, alt_oe, alt_smp, ext;
   int error_cnt = 0;
   int tests_run = 0;
   localparam logic [7:0] PB = IDX_PB_DATA;
   localparam logic [7:0] PC = IDX_PC_DATA;
   localparam logic [7:0] PD = IDX_PD_DATA;

   gpio_port u_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE_OUT(pin_oe), .ALT_DATA_IN(alt_data), .ALT_OE_IN(alt_oe),
      .ALT_SAMPLED_OUT(alt_smp), .IRQ_OUT(irq));
   pin_model u_pads (.pad_out_in(pin_out), .pad_oe_in(pin_oe), .ext_in(ext), .pin_out(pin_in));

   // ****************************************
   // clock, verdict, watchdog
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task end_sim();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   // whole run is a few hundred cycles; this leaves a wide margin
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end

   // ****************************************
   // apb master
   // ****************************************
   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no wait count assumed here; a slave that never answers is caught by the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task rd(input logic [7:0] idx);
      apb(1'b0, idx, 32'h00000000);
   endtask : rd

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // data write clears edge requests, then the sticky status is wiped
   task clr(input logic [7:0] d);
      wr(PB, {24'h000000, d});
      wr(IDX_IRQ_STATUS, 32'h00FFFFFF);
   endtask : clr

   // ****************************************
   // tests
   // ****************************************
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      ext = 24'h0000A0;
      alt_data = '0;
      alt_oe = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      tick(4);
      `CHK(pin_oe, 24'h000000)
      rd(PB + OFS_DDR);
      `CHK(rdata[7:0], 8'hFF)
      rd(PB + OFS_ALT1);
      `CHK(rdata[7:0], 8'h00)
      rd(PB);
      `CHK(rdata[7:0], 8'hA0)
      rd(8'h50);
      `CHK(rerr, 1'b1)
      `CHK(rdata, 32'h00000000)
      $display("test reset and map done");
      // port c: output, then reserved hi-z with the board driving
      wr(PC + OFS_DDR, 32'h00000000);
      wr(PC, 32'h0000003C);
      tick(4);
      `CHK(pin_oe[15:8], 8'hFF)
      `CHK(pin_out[15:8], 8'h3C)
      rd(PC);
      `CHK(rdata[7:0], 8'h3C)
      ext <= 24'h005AA0;
      wr(PC + OFS_ALT1, 32'h000000FF);
      tick(4);
      `CHK(pin_oe[15:8], 8'h00)
      rd(PC);
      `CHK(rdata[7:0], 8'h5A)
      // port d: alternate function owns drive and enable, data ignored
      alt_data <= 24'h960000;
      alt_oe <= 24'h0F0000;
      ext <= 24'hA05AA0;
      wr(PD + OFS_ALT2, 32'h000000FF);
      wr(PD + OFS_DDR, 32'h00000000);
      wr(PD, 32'h000000FF);
      tick(6);
      `CHK(pin_oe[23:16], 8'h0F)
      `CHK(pin_out[19:16], 4'h6)
      `CHK(alt_smp[23:16], 8'hA6)
      $display("test output modes done");
      // port b: pin0 dual edge, pin1 single edge, pin2 level; data preset first
      wr(PB, 32'h00000007);
      wr(PB + OFS_ALT2, 32'h00000006);
      wr(PB + OFS_ALT1, 32'h00000003);
      wr(PB + OFS_DDR, 32'h000000FD);
      wr(IDX_IRQ_MASK, 32'h00FFFFFF);
      clr(8'h07);
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[23:0], 24'h000000)
      ext[0] <= 1'b1;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b001)
      `CHK(irq, 1'b1)
      wr(PB, 32'h00000006);
      wr(IDX_IRQ_STATUS, 32'h00000001);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[0], 1'b1)
      clr(8'h07);
      tick(4);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b000)
      `CHK(irq, 1'b0)
      ext[0] <= 1'b0;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b001)
      clr(8'h07);
      $display("test dual edge done");
      ext[1] <= 1'b1;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b010)
      wr(IDX_IRQ_STATUS, 32'h00000002);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[1], 1'b1)
      clr(8'h07);
      ext[1] <= 1'b0;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b000)
      // data 01: pin1 now falling edge, pin2 matches a low pin
      clr(8'h01);
      ext[1] <= 1'b1;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b100)
      ext[1] <= 1'b0;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b110)
      clr(8'h07);
      tick(4);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b000)
      $display("test single edge done");
      // a one-cycle glitch must not count as a level
      ext[2] <= 1'b1;
      @(posedge clk);
      ext[2] <= 1'b0;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b000)
      ext[2] <= 1'b1;
      tick(8);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b100)
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_MASK, 32'h00000000);
      tick(3);
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 32'h00FFFFFF);
      wr(IDX_IRQ_STATUS, 32'h00000004);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2], 1'b1)
      ext[2] <= 1'b0;
      tick(8);
      wr(IDX_IRQ_STATUS, 32'h00000004);
      rd(IDX_IRQ_STATUS);
      `CHK(rdata[2:0], 3'b000)
      tick(3);
      `CHK(irq, 1'b0)
      $display("test level done");
      end_sim();
   end
endmodule : testbench
